// File: include/ict_params.svh
/*
 * Timing constants for the instruction cycle sequencer: base clock,
 * read and write counts per instruction class.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`ifndef ICT_PARAMS_SVH
`define ICT_PARAMS_SVH
`define ICT_IMM_BW_CLK      8'h10
`define ICT_IMM_BW_RD       5'h04
`define ICT_IMM_L_CLK       8'h1C
`define ICT_IMM_L_RD        5'h06
`define ICT_QLI_CLK         8'h08
`define ICT_QLI_RD          5'h02
`define ICT_CMP_LREG_CLK    8'h1A
`define ICT_CMP_LMEM_CLK    8'h18
`define ICT_CMP_L_RD        5'h06
`define ICT_SHR_BW_BASE     8'h0A
`define ICT_SHR_L_BASE      8'h0C
`define ICT_SHR_RD          5'h02
`define ICT_SHM_CLK         8'h10
`define ICT_SHM_RD          5'h02
`define ICT_SHM_WR          5'h02
`define ICT_BND_OK_CLK      8'h0E
`define ICT_BND_OK_RD       5'h02
`define ICT_BND_TRAP_CLK    8'h44
`define ICT_BND_TRAP_RD     5'h08
`define ICT_BND_TRAP_WR     5'h06
`endif

// File: include/ict_pkg.sv
/*
 * Types for the instruction cycle sequencer.
 * Assumes ict_params.svh is on the include path.
 */
`default_nettype none
package ict_pkg;
	typedef enum logic [2:0] {
		ICT_OP_IMM_OR,
		ICT_OP_IMM_AND,
		ICT_OP_QLI,
		ICT_OP_IMM_CMP,
		ICT_OP_SHIFT,
		ICT_OP_BOUNDS
	} ict_op_t;
	typedef enum logic [1:0] {
		ICT_SZ_BYTE,
		ICT_SZ_WORD,
		ICT_SZ_LONG
	} ict_size_t;
	// one instruction request
	typedef struct packed {
		ict_op_t   op;
		ict_size_t size;
		logic      memDest;
		logic      trapTaken;
		logic [5:0] shiftCount;
		logic [7:0] eaClk;
		logic [4:0] eaRd;
		logic [4:0] eaWr;
	} ict_req_t;
	// cost triple
	typedef struct packed {
		logic [7:0] clk;
		logic [4:0] rd;
		logic [4:0] wr;
		logic       legal;
	} ict_cost_t;
	typedef enum logic [1:0] {
		ICT_ST_IDLE,
		ICT_ST_READ,
		ICT_ST_WRITE,
		ICT_ST_IDLE_CLK
	} ict_state_t;
endpackage
`default_nettype wire

// File: hw/ict_cost_table.sv
/*
 * Combinational cost lookup: returns the clock/read/write triple for one
 * instruction request, with effective-address cost folded in where due.
 * Assumes the request fields are stable while it is read.
 */
`include "ict_params.svh"
`default_nettype none
module ict_cost_table (
	input  wire ict_pkg::ict_req_t  req,
	output var  ict_pkg::ict_cost_t cost
);
	// ============================================================
	// lookup
	always_comb begin
		cost = '0;
		cost.legal = 1'b1;
		case (req.op)
			ict_pkg::ICT_OP_IMM_OR, ict_pkg::ICT_OP_IMM_AND: begin
				// data register destination only in this block
				cost.legal = !req.memDest;
				if (req.size == ict_pkg::ICT_SZ_LONG) begin
					cost.clk = `ICT_IMM_L_CLK;
					cost.rd  = `ICT_IMM_L_RD;
				end else begin
					cost.clk = `ICT_IMM_BW_CLK;
					cost.rd  = `ICT_IMM_BW_RD;
				end
			end
			ict_pkg::ICT_OP_QLI: begin
				cost.legal = !req.memDest && req.size == ict_pkg::ICT_SZ_LONG;
				cost.clk   = `ICT_QLI_CLK;
				cost.rd    = `ICT_QLI_RD;
			end
			ict_pkg::ICT_OP_IMM_CMP: begin
				cost.legal = req.size == ict_pkg::ICT_SZ_LONG;
				cost.clk   = req.memDest ? `ICT_CMP_LMEM_CLK : `ICT_CMP_LREG_CLK;
				cost.rd    = `ICT_CMP_L_RD;
			end
			ict_pkg::ICT_OP_SHIFT: begin
				if (req.memDest) begin
					cost.legal = req.size == ict_pkg::ICT_SZ_WORD;
					cost.clk   = 8'(`ICT_SHM_CLK + req.eaClk);
					cost.rd    = 5'(`ICT_SHM_RD + req.eaRd);
					cost.wr    = 5'(`ICT_SHM_WR + req.eaWr);
				end else begin
					if (req.size == ict_pkg::ICT_SZ_LONG)
						cost.clk = 8'(`ICT_SHR_L_BASE + {req.shiftCount, 1'b0});
					else
						cost.clk = 8'(`ICT_SHR_BW_BASE + {req.shiftCount, 1'b0});
					cost.rd = `ICT_SHR_RD;
				end
			end
			ict_pkg::ICT_OP_BOUNDS: begin
				if (req.trapTaken) begin
					cost.clk = 8'(`ICT_BND_TRAP_CLK + req.eaClk);
					cost.rd  = 5'(`ICT_BND_TRAP_RD + req.eaRd);
					cost.wr  = 5'(`ICT_BND_TRAP_WR + req.eaWr);
				end else begin
					cost.clk = `ICT_BND_OK_CLK;
					cost.rd  = `ICT_BND_OK_RD;
				end
			end
			default: cost.legal = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// File: hw/ict_sequencer.sv
/*
 * Instruction cycle sequencer: takes one instruction request and paces
 * its bus read cycles, bus write cycles and idle clocks so that the whole
 * instruction lasts exactly its tabulated clock count.
 * Assumes core_clk at 100 MHz, requests from logic on the same clock,
 * and a bus that completes each cycle on a one-cycle ack pulse.
 * Effective-address clocks, reads and writes arrive with the request and
 * are summed without range checks: the caller keeps each total within
 * the 8-bit clock and 5-bit bus-cycle counters.
 * A bus slower than the budget stretches the instruction: done then waits
 * for the last acknowledge, so the clock figures hold only for a bus that
 * keeps pace.
 * A refused request answers with done and illegal one edge after it is
 * taken and starts no bus cycle.
 * Only timing is paced here: no operand data passes through this block,
 * and the bus strobes carry no address.
 * clkEn low freezes every counter and strobe, so a frozen cycle counts
 * toward neither the clock budget nor the bus cycles.
 */
//
// Summary of operation
// - on a bus that keeps pace, each instruction ends with exact clock, read and write counts together.
// - flagged entries add effective-address clocks, reads and writes to base.
// - immediate or/and to data register: 16 clocks 4 reads; long 28, 6.
// - quick load immediate is long, data register only: 8 clocks 2 reads.
// - immediate compare long: register 26 clocks, memory 24, both 6 reads.
// - register shifts take 10+2n clocks byte/word, 12+2n long, 2 reads.
// - memory shifts are word only: 16 clocks, 2 reads, 2 writes plus address.
// - bounds check without trap takes 14 clocks and 2 reads.
// - bounds check trap takes 68 clocks, 8 reads, 6 writes plus address.
`include "ict_params.svh"
`default_nettype none
module ict_sequencer (
	input  wire logic               core_clk,
	input  wire logic               rst_b,
	input  wire logic               clkEn,
	input  wire logic               reqValid,
	input  wire ict_pkg::ict_req_t  reqIn,
	input  wire logic               busAck,
	output logic                    reqReady,
	output logic                    busRead,
	output logic                    busWrite,
	output logic                    done,
	output logic                    illegal,
	output logic [7:0]              clkUsed,
	output logic [4:0]              rdUsed,
	output logic [4:0]              wrUsed
);
	typedef struct packed {
		ict_pkg::ict_state_t st;
		logic [7:0]          clkLeft;
		logic [4:0]          rdLeft;
		logic [4:0]          wrLeft;
		logic [7:0]          clkCnt;
		logic [4:0]          rdCnt;
		logic [4:0]          wrCnt;
		logic                ready;
		logic                rd;
		logic                wr;
		logic                done;
		logic                illegal;
	} ict_seq_state_t;

	ict_seq_state_t    s_q;
	ict_seq_state_t    s_d;
	ict_pkg::ict_cost_t cost;

	// ============================================================
	// cost lookup
	ict_cost_table u_cost (
		.req  (reqIn),
		.cost (cost)
	);

	// ============================================================
	// helpers
	// pick next bus phase: reads first, then writes, then idle fill
	function automatic ict_pkg::ict_state_t next_phase(input logic [4:0] r,
	                                                   input logic [4:0] w);
		if (r != 5'h00)
			return ict_pkg::ICT_ST_READ;
		else if (w != 5'h00)
			return ict_pkg::ICT_ST_WRITE;
		else
			return ict_pkg::ICT_ST_IDLE_CLK;
	endfunction

	// one step up a bus-cycle counter
	function automatic logic [4:0] inc5(input logic [4:0] v);
		return 5'(v + 5'h01);
	endfunction

	// one step down a bus-cycle budget, held at zero
	function automatic logic [4:0] dec5(input logic [4:0] v);
		if (v == 5'h00)
			return 5'h00;
		else
			return 5'(v - 5'h01);
	endfunction

	// one clock of the budget spent
	function automatic ict_seq_state_t tick(input ict_seq_state_t s);
		ict_seq_state_t t;
		t         = s;
		t.clkCnt  = 8'(s.clkCnt + 8'h01);
		t.clkLeft = 8'(s.clkLeft - 8'h01);
		return t;
	endfunction

	// phase and its bus strobes move together so they never disagree
	function automatic ict_seq_state_t enter_phase(input ict_seq_state_t      s,
	                                               input ict_pkg::ict_state_t ph);
		ict_seq_state_t t;
		t    = s;
		t.st = ph;
		t.rd = ph == ict_pkg::ICT_ST_READ;
		t.wr = ph == ict_pkg::ICT_ST_WRITE;
		return t;
	endfunction

	// end once the budget and every bus cycle are used up; a slow bus
	// that overran the budget holds the count at one until it catches up
	function automatic ict_seq_state_t close_out(input ict_seq_state_t s,
	                                             input logic [7:0]     leftNow);
		ict_seq_state_t t;
		t = s;
		if (leftNow == 8'h01 && t.rdLeft == 5'h00 && t.wrLeft == 5'h00) begin
			t.st    = ict_pkg::ICT_ST_IDLE;
			t.rd    = 1'b0;
			t.wr    = 1'b0;
			t.done  = 1'b1;
			t.ready = 1'b1;
		end else if (leftNow <= 8'h01) begin
			t.clkLeft = 8'h01;
		end
		return t;
	endfunction

	// load a taken request: counters restart and stand until the next accept
	function automatic ict_seq_state_t start_instr(input ict_seq_state_t     s,
	                                               input ict_pkg::ict_cost_t c);
		ict_seq_state_t t;
		t         = s;
		t.ready   = 1'b0;
		t.illegal = !c.legal;
		t.clkCnt  = 8'h00;
		t.rdCnt   = 5'h00;
		t.wrCnt   = 5'h00;
		if (c.legal) begin
			t.clkLeft = c.clk;
			t.rdLeft  = c.rd;
			t.wrLeft  = c.wr;
			t         = enter_phase(t, next_phase(c.rd, c.wr));
		end else begin
			// refused: answer at once, no bus cycles
			t.done  = 1'b1;
			t.ready = 1'b1;
		end
		return t;
	endfunction

	// ============================================================
	// next state
	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		s_d.rd   = 1'b0;
		s_d.wr   = 1'b0;
		case (s_q.st)
			ict_pkg::ICT_ST_IDLE: begin
				s_d.ready = 1'b1;
				if (reqValid && s_q.ready)
					s_d = start_instr(s_d, cost);
			end
			ict_pkg::ICT_ST_READ: begin
				s_d = tick(s_d);
				if (busAck) begin
					s_d.rdLeft = dec5(s_q.rdLeft);
					s_d.rdCnt  = inc5(s_q.rdCnt);
				end
				s_d = enter_phase(s_d, next_phase(s_d.rdLeft, s_d.wrLeft));
				s_d = close_out(s_d, s_q.clkLeft);
			end
			ict_pkg::ICT_ST_WRITE: begin
				s_d = tick(s_d);
				if (busAck) begin
					s_d.wrLeft = dec5(s_q.wrLeft);
					s_d.wrCnt  = inc5(s_q.wrCnt);
				end
				s_d = enter_phase(s_d, next_phase(s_d.rdLeft, s_d.wrLeft));
				s_d = close_out(s_d, s_q.clkLeft);
			end
			ict_pkg::ICT_ST_IDLE_CLK: begin
				// bus quiet: only the clock budget runs down
				s_d = tick(s_d);
				s_d = enter_phase(s_d, ict_pkg::ICT_ST_IDLE_CLK);
				s_d = close_out(s_d, s_q.clkLeft);
			end
			default: s_d.st = ict_pkg::ICT_ST_IDLE;
		endcase
	end

	// ============================================================
	// state register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			s_q <= '0;
		else if (clkEn)
			s_q <= s_d;
	end

	// ============================================================
	// outputs
	assign reqReady = s_q.ready;
	assign busRead  = s_q.rd;
	assign busWrite = s_q.wr;
	assign done     = s_q.done;
	assign illegal  = s_q.illegal;
	assign clkUsed  = s_q.clkCnt;
	assign rdUsed   = s_q.rdCnt;
	assign wrUsed   = s_q.wrCnt;
endmodule
`default_nettype wire

// File: sim/ict_bus_model.sv
/*
 * Bus responder standing in for memory and peripherals.
 * Assumes one clock shared with the sequencer.
 */
`default_nettype none
module ict_bus_model (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic       busRead,
	input  wire logic       busWrite,
	input  wire logic [3:0] ackDelay,
	output logic            busAck
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] waitQ;
	// ack after ackDelay wait states; zero gives the fastest bus
	assign busAck = (busRead | busWrite) && waitQ == ackDelay;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			waitQ <= 4'h0;
		else if (busAck || !(busRead | busWrite))
			waitQ <= 4'h0;
		else
			waitQ <= waitQ + 4'h1;
	end
endmodule
`default_nettype wire

// File: sim/ict_sequencer_checker.sv
/*
 * Port-level assertions for the sequencer, bound to its top.
 * Assumes ict_pkg is compiled first.
 */
`default_nettype none
module ict_sequencer_checker (
	input wire logic              core_clk,
	input wire logic              rst_b,
	input wire logic              clkEn,
	input wire logic              reqValid,
	input wire ict_pkg::ict_req_t reqIn,
	input wire logic              busAck,
	input wire logic              reqReady,
	input wire logic              busRead,
	input wire logic              busWrite,
	input wire logic              done,
	input wire logic              illegal
);
	timeunit 1ns;
	timeprecision 1ps;
	logic take;
	logic qliOk;
	assign take = clkEn && reqValid && reqReady;
	assign qliOk = reqIn.op == ict_pkg::ICT_OP_QLI && reqIn.size == ict_pkg::ICT_SZ_LONG
		&& !reqIn.memDest;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_rw_excl: assert property (!(busRead && busWrite))
		else $error("read and write at once");
	a_done_pulse: assert property (done && clkEn |=> !done)
		else $error("done longer than one cycle");
	a_done_ready: assert property (done |-> reqReady)
		else $error("done while busy");
	a_read_hold: assert property (busRead && !busAck |=> busRead)
		else $error("read dropped before ack");
	a_qli_busy: assert property (take && qliOk |=> (!done && !reqReady)[*8] ##1 done)
		else $error("quick load finished early");
	a_qli_illegal: assert property (take && reqIn.op == ict_pkg::ICT_OP_QLI
		&& reqIn.size != ict_pkg::ICT_SZ_LONG |=> done && illegal && !busRead)
		else $error("bad quick load not refused");
	a_or_nowrite: assert property (take && reqIn.op == ict_pkg::ICT_OP_IMM_OR |=> !busWrite[*8])
		else $error("write during immediate or");
	a_write_order: assert property (busWrite |=> !busRead)
		else $error("read after write");
endmodule
bind ict_sequencer ict_sequencer_checker ict_sequencer_checker_inst (.core_clk, .rst_b,
	.clkEn, .reqValid, .reqIn, .busAck, .reqReady, .busRead, .busWrite, .done, .illegal);
`default_nettype wire

// File: sim/testbench.sv
/*
 * Self-checking bench for the sequencer with a bus responder.
 * Assumes ict_pkg and the design files are compiled first.
 */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic              core_clk = 1'b0;
	logic              rst_b = 1'b0;
	logic              clkEn = 1'b1;
	logic              reqValid = 1'b0;
	ict_pkg::ict_req_t reqIn = '0;
	logic [3:0]        ackDelay = 4'h0;
	logic              busAck, reqReady, busRead, busWrite, done, illegal;
	logic [7:0]        clkUsed;
	logic [4:0]        rdUsed, wrUsed;
	int                n_fail = 0;
	int                comparisons = 0;
	always #5 core_clk = ~core_clk;
	ict_sequencer ict_sequencer_inst (.core_clk, .rst_b, .clkEn, .reqValid, .reqIn, .busAck,
		.reqReady, .busRead, .busWrite, .done, .illegal, .clkUsed, .rdUsed, .wrUsed);
	ict_bus_model ict_bus_model_inst (.core_clk, .rst_b, .busRead, .busWrite, .ackDelay, .busAck);
	task automatic wrap_up();
		if (n_fail == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic timeout();
		n_fail++;
		$display("ERROR %0t wait ran out", $time);
		wrap_up();
	endtask
	// f = {memDest, trapTaken}; xc of 8'hFF skips the clock count
	task automatic run(input logic [2:0] op, input logic [1:0] sz, input logic [1:0] f,
		input logic [5:0] n, input logic [7:0] xc, input logic [4:0] xr,
		input logic [4:0] xw, input logic xi);
		logic [7:0] c;
		logic [4:0] r;
		logic [4:0] w;
		int         k;
		c = 8'h00;
		r = 5'h00;
		w = 5'h00;
		@(posedge core_clk);
		reqIn <= '{ict_pkg::ict_op_t'(op), ict_pkg::ict_size_t'(sz), f[1], f[0], n, 8'h04,
			5'h01, 5'h00};
		reqValid <= 1'b1;
		// taken at the first edge that samples ready and enable together
		for (k = 0; k < 300; k++) begin
			@(posedge core_clk);
			if (reqReady === 1'b1 && clkEn === 1'b1)
				break;
		end
		if (k == 300)
			timeout();
		reqValid <= 1'b0;
		for (k = 0; k < 300; k++) begin
			@(posedge core_clk);
			if (done === 1'b1)
				break;
			if (clkEn === 1'b1) begin
				c++;
				if (busAck === 1'b1 && busRead === 1'b1)
					r++;
				if (busAck === 1'b1 && busWrite === 1'b1)
					w++;
			end
		end
		if (k == 300)
			timeout();
		check({7'h00, illegal}, {7'h00, xi});
		check({3'h0, r}, {3'h0, xr});
		check({3'h0, w}, {3'h0, xw});
		if (xc != 8'hFF)
			check(c, xc);
		if (xc != 8'hFF)
			check(clkUsed, xc);
		check({3'h0, rdUsed}, {3'h0, xr});
		check({3'h0, wrUsed}, {3'h0, xw});
	endtask
	task automatic t_imm();
		run(3'h0, 2'h0, 2'h0, 6'h00, 8'h10, 5'h04, 5'h00, 1'b0);
		run(3'h0, 2'h2, 2'h0, 6'h00, 8'h1C, 5'h06, 5'h00, 1'b0);
		run(3'h1, 2'h1, 2'h0, 6'h00, 8'h10, 5'h04, 5'h00, 1'b0);
		run(3'h1, 2'h2, 2'h0, 6'h00, 8'h1C, 5'h06, 5'h00, 1'b0);
		run(3'h0, 2'h1, 2'h2, 6'h00, 8'h00, 5'h00, 5'h00, 1'b1);
	endtask
	task automatic t_qli();
		run(3'h2, 2'h2, 2'h0, 6'h00, 8'h08, 5'h02, 5'h00, 1'b0);
		run(3'h2, 2'h1, 2'h0, 6'h00, 8'h00, 5'h00, 5'h00, 1'b1);
		run(3'h2, 2'h2, 2'h2, 6'h00, 8'h00, 5'h00, 5'h00, 1'b1);
	endtask
	task automatic t_cmp();
		run(3'h3, 2'h2, 2'h0, 6'h00, 8'h1A, 5'h06, 5'h00, 1'b0);
		run(3'h3, 2'h2, 2'h2, 6'h00, 8'h18, 5'h06, 5'h00, 1'b0);
		run(3'h3, 2'h0, 2'h0, 6'h00, 8'h00, 5'h00, 5'h00, 1'b1);
	endtask
	task automatic t_shift();
		run(3'h4, 2'h0, 2'h0, 6'h00, 8'h0A, 5'h02, 5'h00, 1'b0);
		run(3'h4, 2'h1, 2'h0, 6'h3F, 8'h88, 5'h02, 5'h00, 1'b0);
		run(3'h4, 2'h2, 2'h0, 6'h03, 8'h12, 5'h02, 5'h00, 1'b0);
		run(3'h4, 2'h1, 2'h2, 6'h00, 8'h14, 5'h03, 5'h02, 1'b0);
		run(3'h4, 2'h0, 2'h2, 6'h00, 8'h00, 5'h00, 5'h00, 1'b1);
	endtask
	task automatic t_bounds();
		run(3'h5, 2'h1, 2'h0, 6'h00, 8'h0E, 5'h02, 5'h00, 1'b0);
		run(3'h5, 2'h1, 2'h1, 6'h00, 8'h48, 5'h09, 5'h06, 1'b0);
	endtask
	task automatic t_stall();
		ackDelay <= 4'h2;
		run(3'h4, 2'h1, 2'h2, 6'h00, 8'h14, 5'h03, 5'h02, 1'b0);
		ackDelay <= 4'h0;
		fork
			run(3'h4, 2'h1, 2'h2, 6'h00, 8'h14, 5'h03, 5'h02, 1'b0);
			begin
				repeat (5) @(posedge core_clk);
				clkEn <= 1'b0;
				repeat (3) @(posedge core_clk);
				clkEn <= 1'b1;
			end
		join
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		t_imm();
		t_qli();
		t_cmp();
		t_shift();
		t_bounds();
		t_stall();
		wrap_up();
	end
endmodule
`default_nettype wire
